// >>> core/sbs_consts.svh
// Constants for the stepper bridge switch control block
`ifndef SBS_CONSTS_SVH
`define SBS_CONSTS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SBS_CLK_NS      20
`define SBS_DEAD_NS     300
`define SBS_DEAD_CYC    ((`SBS_DEAD_NS + `SBS_CLK_NS - 1) / `SBS_CLK_NS)
`define SBS_SENSE_CYC   5'h18

// ----------------------------------------------------------------
// Oscillator ramp thresholds in millivolts
// ----------------------------------------------------------------
`define SBS_OSC_HI_MV   12'h7D0
`define SBS_OSC_LO_MV   12'h1F4

// ----------------------------------------------------------------
// Switch patterns {hs_a, hs_b, ls_a, ls_b}
// ----------------------------------------------------------------
`define SBS_PAT_OFF     4'h0
`define SBS_PAT_CHG_FWD 4'h9
`define SBS_PAT_FST_FWD 4'h6
`define SBS_PAT_SLOW    4'h3

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
`define SBS_ADDR_CTRL   8'h00
`define SBS_ADDR_STAT   8'h04
`define SBS_ADDR_MASK   8'h08
`define SBS_ADDR_STATE  8'h0C
`define SBS_CTRL_RST    1'h1
`define SBS_ST_STEP     0
`define SBS_ST_THERM    1
`define SBS_ST_CHOP     2
`define SBS_ST_W        3

`endif

// >>> core/sbs_pkg.sv
// Types shared by the stepper bridge switch control modules
package sbs_pkg;
    typedef enum logic [2:0] {
        SBS_PH_CHARGE = 3'b001,
        SBS_PH_SLOW   = 3'b010,
        SBS_PH_FAST   = 3'b100
    } sbs_phase_e;

    typedef enum logic [1:0] {
        SBS_DT_HOLD = 2'b01,
        SBS_DT_DEAD = 2'b10
    } sbs_dead_e;

    typedef logic [3:0] sbs_gate_t;
endpackage : sbs_pkg

// >>> core/sbs_gate_if.sv
// Gate request and gate state between controller and dead-time stage
`timescale 1ns/10ps
`default_nettype none
interface sbs_gate_if;
    sbs_pkg::sbs_gate_t want;
    logic               kill;
    sbs_pkg::sbs_gate_t gate;
    logic               busy;

    modport ctrl (output want, output kill, input gate, input busy);
    modport dead (input want, input kill, output gate, output busy);
endinterface : sbs_gate_if
`default_nettype wire

// >>> core/sbs_dead_time.sv
// Dead-time insertion between bridge switch patterns
`timescale 1ns/10ps
`default_nettype none
`include "sbs_consts.svh"
module sbs_dead_time #(
    parameter int DEAD_CYC = `SBS_DEAD_CYC
) (
    // Clock and reset
    input  wire logic   ref_clk_i,
    input  wire logic   reset_n_i,
    // Gate path
    sbs_gate_if.dead    gif
);
    localparam int CW = $clog2(DEAD_CYC + 1);

    sbs_pkg::sbs_dead_e state_reg;
    logic [CW-1:0]      cnt_reg;
    sbs_pkg::sbs_gate_t gate_reg;
    logic [CW-1:0]      zero_reg;

    assign gif.gate = gate_reg;
    assign gif.busy = (state_reg == sbs_pkg::SBS_DT_DEAD);

    // ----------------------------------------------------------------
    // Pattern sequencing
    // ----------------------------------------------------------------
    // RULE3 RULE16 counted dead gap
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_reg <= sbs_pkg::SBS_DT_HOLD;
            cnt_reg   <= '0;
            gate_reg  <= `SBS_PAT_OFF;
        end
        else if (gif.kill || gif.want == `SBS_PAT_OFF)
        begin
            // Turning off never waits: no overlap is possible
            state_reg <= sbs_pkg::SBS_DT_HOLD;
            gate_reg  <= `SBS_PAT_OFF;
        end
        else
        begin
            unique case (state_reg)
                sbs_pkg::SBS_DT_HOLD:
                    if (gif.want != gate_reg)
                    begin
                        state_reg <= sbs_pkg::SBS_DT_DEAD;
                        cnt_reg   <= CW'(DEAD_CYC - 1);
                        gate_reg  <= `SBS_PAT_OFF;
                    end
                sbs_pkg::SBS_DT_DEAD:
                    if (cnt_reg == '0)
                    begin
                        state_reg <= sbs_pkg::SBS_DT_HOLD;
                        gate_reg  <= gif.want;
                    end
                    else
                        cnt_reg <= cnt_reg - 1'b1;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            zero_reg <= '0;
        else if (gate_reg != `SBS_PAT_OFF)
            zero_reg <= '0;
        else if (zero_reg != CW'(DEAD_CYC))
            zero_reg <= zero_reg + 1'b1;
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    chk_dead_gap_len: assert property ( // RULE3
        (gate_reg != `SBS_PAT_OFF && $past(gate_reg) == `SBS_PAT_OFF)
        |-> $past(zero_reg) == CW'(DEAD_CYC - 1)
            || $past(zero_reg) == CW'(DEAD_CYC))
        else $error("pattern applied before dead gap ended");

    chk_no_direct_swap: assert property ( // RULE16
        (gate_reg != `SBS_PAT_OFF && $past(gate_reg) != `SBS_PAT_OFF)
        |-> gate_reg == $past(gate_reg))
        else $error("pattern changed without dead gap");
endmodule : sbs_dead_time
`default_nettype wire

// >>> core/sbs_chop_clock.sv
// Chopping clock from the oscillator ramp with hysteresis
`timescale 1ns/10ps
`default_nettype none
`include "sbs_consts.svh"
module sbs_chop_clock #(
    parameter logic [11:0] HI_MV = `SBS_OSC_HI_MV,
    parameter logic [11:0] LO_MV = `SBS_OSC_LO_MV
) (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        reset_n_i,
    // Ramp sample and chopping clock
    input  wire logic [11:0] osc_mv_i,
    output logic             chop_lvl_o,
    output logic             chop_rise_o
);
    logic lvl_reg;
    logic rise_reg;

    assign chop_lvl_o  = lvl_reg;
    assign chop_rise_o = rise_reg;

    // RULE4 hysteresis comparator
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            lvl_reg  <= 1'b0;
            rise_reg <= 1'b0;
        end
        else
        begin
            if (osc_mv_i >= HI_MV)
                lvl_reg <= 1'b1;
            else if (osc_mv_i <= LO_MV)
                lvl_reg <= 1'b0;
            rise_reg <= (osc_mv_i >= HI_MV) && !lvl_reg;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    chk_osc_hyst_band: assert property ( // RULE4
        (osc_mv_i >= HI_MV |=> lvl_reg)
        and (osc_mv_i <= LO_MV |=> !lvl_reg)
        and ((osc_mv_i < HI_MV && osc_mv_i > LO_MV)
             |=> lvl_reg == $past(lvl_reg)))
        else $error("chopping clock broke hysteresis");
endmodule : sbs_chop_clock
`default_nettype wire

// >>> core/sbs_bridge_ctrl.sv
// Top of the stepper bridge switch control block
//
// How it works
// RULE1 - Forward current: charge hs_a+ls_b, slow both low, fast hs_b+ls_a.
// RULE2 - Reverse current: charge hs_b+ls_a, slow both low, fast hs_a+ls_b.
// RULE3 - Every pattern change keeps switches off about 300 ns first.
// RULE4 - Chop clock high at ramp 2 V or more, low at 0.5 V or less.
// RULE5 - Reset released, enable low: outputs off, step counter still advances.
// RULE6 - Enable high, reset low: step clocks ignored, initial state held.
// RULE7 - Outputs driven only with reset released and enable high.
// RULE8 - Enable low forces all four switches off at once.
// RULE9 - Controller keeps inputs low during supply power up.
// RULE10 - Controller raises reset and enable last, drops them first.
// RULE11 - Thermal trip switches all bridge outputs off.
// RULE12 - Reset low: initial position, initial state flag driven low.
// RULE13 - After reset release, next step edge moves past initial state.
// RULE14 - Step clock resets chop counter at next chop rise, then charge.
// RULE15 - Enable low gates output stage only; sequencing keeps going.
// RULE16 - Dead gap counted in logic clocks, rounded up.
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "sbs_consts.svh"
module sbs_bridge_ctrl #(
    parameter int POS_W  = 4,
    parameter int CHOP_W = 8
) (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        reset_n_i,
    // Step controller pins
    input  wire logic        step_clk_i,
    input  wire logic        drive_reset_n_i,
    input  wire logic        enable_i,
    input  wire logic        dir_i,
    // Chopper inputs
    input  wire logic [11:0] osc_mv_i,
    input  wire logic [2:0]  phase_req_i,
    input  wire logic        thermal_trip_i,
    // Bridge switches
    output logic             high_side_switch_a_o,
    output logic             high_side_switch_b_o,
    output logic             low_side_switch_a_o,
    output logic             low_side_switch_b_o,
    // Initial state flag, open drain
    output logic             initial_state_flag_o,
    output logic             initial_state_flag_oe_o,
    // Register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic [31:0]      reg_rdata_o,
    output logic             irq_o
);
    sbs_gate_if gif ();

    logic                   step_prev_reg;
    logic                   therm_prev_reg;
    logic [POS_W-1:0]       pos_reg;
    logic                   pend_reg;
    logic [CHOP_W-1:0]      chop_cnt_reg;
    logic [4:0]             sense_cnt_reg;
    logic                   flag_oe_reg;
    logic                   ctrl_en_reg;
    logic [`SBS_ST_W-1:0]   status_reg;
    logic [`SBS_ST_W-1:0]   status_next;
    logic [`SBS_ST_W-1:0]   mask_reg;
    logic [31:0]            rdata_reg;
    logic                   irq_reg;

    logic                   step_rise;
    logic                   chop_rise;
    logic                   chop_restart;
    logic                   cur_neg;
    logic                   outputs_on;
    logic [`SBS_ST_W-1:0]   events;
    sbs_pkg::sbs_phase_e    eff_phase;
    sbs_pkg::sbs_gate_t     pattern;

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    sbs_chop_clock u_chop (
        .ref_clk_i   (ref_clk_i),
        .reset_n_i   (reset_n_i),
        .osc_mv_i    (osc_mv_i),
        .chop_lvl_o  (),
        .chop_rise_o (chop_rise)
    );

    sbs_dead_time u_dead (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .gif       (gif.dead)
    );

    assign high_side_switch_a_o    = gif.gate[3];
    assign high_side_switch_b_o    = gif.gate[2];
    assign low_side_switch_a_o     = gif.gate[1];
    assign low_side_switch_b_o     = gif.gate[0];
    // Open drain: data stays low, the enable moves the pin
    assign initial_state_flag_o    = 1'b0;
    assign initial_state_flag_oe_o = flag_oe_reg;
    assign reg_rdata_o             = rdata_reg;
    assign irq_o                   = irq_reg;

    // ----------------------------------------------------------------
    // Step position
    // ----------------------------------------------------------------
    // Pins arrive synchronous, so a single delay finds the edge
    assign step_rise = step_clk_i && !step_prev_reg;
    assign cur_neg   = pos_reg[POS_W-1];

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            step_prev_reg  <= 1'b0;
            therm_prev_reg <= 1'b0;
        end
        else
        begin
            step_prev_reg  <= step_clk_i;
            therm_prev_reg <= thermal_trip_i;
        end
    end

    // RULE6 RULE12 held at initial position
    // RULE5 RULE13 RULE15 advance ignores enable
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            pos_reg <= '0;
        else if (!drive_reset_n_i)
            pos_reg <= '0;
        else if (step_rise)
            pos_reg <= dir_i ? pos_reg - 1'b1 : pos_reg + 1'b1;
    end

    // RULE12 flag low while at initial position
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            flag_oe_reg <= 1'b1;
        else
            flag_oe_reg <= (pos_reg == '0);
    end

    // ----------------------------------------------------------------
    // Chopping counter and sensing charge
    // ----------------------------------------------------------------
    assign chop_restart = chop_rise && pend_reg;

    // RULE14 restart on the chop rise after a step
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pend_reg      <= 1'b0;
            chop_cnt_reg  <= '0;
            sense_cnt_reg <= '0;
        end
        else
        begin
            // A step landing on the restart edge waits for the next one
            if (step_rise && drive_reset_n_i)
                pend_reg <= 1'b1;
            else if (chop_restart)
                pend_reg <= 1'b0;
            if (chop_restart)
            begin
                chop_cnt_reg  <= '0;
                // Outlasts the dead gap so the charge reaches the bridge
                sense_cnt_reg <= `SBS_SENSE_CYC;
            end
            else
            begin
                if (chop_rise)
                    chop_cnt_reg <= chop_cnt_reg + 1'b1;
                if (sense_cnt_reg != '0)
                    sense_cnt_reg <= sense_cnt_reg - 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Phase to switch pattern
    // ----------------------------------------------------------------
    always_comb
    begin
        if (sense_cnt_reg != '0)
            eff_phase = sbs_pkg::SBS_PH_CHARGE;
        else
        begin
            unique case (phase_req_i)
                3'h1:    eff_phase = sbs_pkg::SBS_PH_CHARGE;
                3'h4:    eff_phase = sbs_pkg::SBS_PH_FAST;
                // Illegal codes fall back to the gentlest decay
                default: eff_phase = sbs_pkg::SBS_PH_SLOW;
            endcase
        end
    end

    // RULE1 RULE2 pattern per direction
    always_comb
    begin
        pattern = `SBS_PAT_OFF;
        unique case (eff_phase)
            sbs_pkg::SBS_PH_CHARGE:
                pattern = cur_neg ? `SBS_PAT_FST_FWD : `SBS_PAT_CHG_FWD;
            sbs_pkg::SBS_PH_FAST:
                pattern = cur_neg ? `SBS_PAT_CHG_FWD : `SBS_PAT_FST_FWD;
            sbs_pkg::SBS_PH_SLOW:
                pattern = `SBS_PAT_SLOW;
        endcase
    end

    // RULE7 RULE8 RULE11 output stage gating
    assign outputs_on = drive_reset_n_i && enable_i && ctrl_en_reg
                        && !thermal_trip_i;
    assign gif.kill   = !outputs_on;
    assign gif.want   = outputs_on ? pattern : `SBS_PAT_OFF;

    // ----------------------------------------------------------------
    // Registers and interrupt
    // ----------------------------------------------------------------
    always_comb
    begin
        events                = '0;
        events[`SBS_ST_STEP]  = step_rise && drive_reset_n_i;
        events[`SBS_ST_THERM] = thermal_trip_i && !therm_prev_reg;
        events[`SBS_ST_CHOP]  = chop_restart;
        status_next           = status_reg;
        if (reg_wr_i && reg_addr_i == `SBS_ADDR_STAT)
            status_next = status_reg & ~reg_wdata_i[`SBS_ST_W-1:0];
        // Set wins over a clear in the same cycle
        status_next = status_next | events;
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ctrl_en_reg <= `SBS_CTRL_RST;
            mask_reg    <= '0;
            status_reg  <= '0;
            irq_reg     <= 1'b0;
        end
        else
        begin
            status_reg <= status_next;
            // Mask writes reach the interrupt a cycle later
            irq_reg    <= |(status_next & mask_reg);
            if (reg_wr_i && reg_addr_i == `SBS_ADDR_CTRL)
                ctrl_en_reg <= reg_wdata_i[0];
            if (reg_wr_i && reg_addr_i == `SBS_ADDR_MASK)
                mask_reg <= reg_wdata_i[`SBS_ST_W-1:0];
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rdata_reg <= '0;
        else if (!reg_rd_i)
            rdata_reg <= '0;
        else
        begin
            unique case (reg_addr_i)
                `SBS_ADDR_CTRL:  rdata_reg <= {31'h0, ctrl_en_reg};
                `SBS_ADDR_STAT:  rdata_reg <= {29'h0, status_reg};
                `SBS_ADDR_MASK:  rdata_reg <= {29'h0, mask_reg};
                `SBS_ADDR_STATE: rdata_reg <= 32'({chop_cnt_reg,
                                     gif.gate, gif.busy, eff_phase,
                                     pos_reg});
                default:         rdata_reg <= '0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    chk_reset_holds_pos: assert property ( // RULE6
        !drive_reset_n_i |=> pos_reg == '0 ##1 flag_oe_reg)
        else $error("position or flag not held in reset");

    chk_step_advance: assert property ( // RULE5
        (drive_reset_n_i && step_rise && !dir_i)
        |=> pos_reg == $past(pos_reg) + 1'b1)
        else $error("step did not advance position");

    chk_gate_needs_both: assert property ( // RULE7
        !(drive_reset_n_i && enable_i) |=> gif.gate == `SBS_PAT_OFF)
        else $error("bridge driven without reset and enable");

    chk_enable_drop_off: assert property ( // RULE8
        $fell(enable_i) |=> gif.gate == `SBS_PAT_OFF)
        else $error("switches not off after enable fell");

    chk_thermal_off: assert property ( // RULE11
        thermal_trip_i |=> gif.gate == `SBS_PAT_OFF [*2])
        else $error("switches on during thermal trip");

    chk_sense_restart: assert property ( // RULE14
        chop_restart |=> chop_cnt_reg == '0
            && sense_cnt_reg == `SBS_SENSE_CYC
            && eff_phase == sbs_pkg::SBS_PH_CHARGE)
        else $error("chop restart missed sensing charge");

    chk_fwd_pattern: assert property ( // RULE1
        (gif.gate != '0 && $past(gif.gate) != '0 && !$past(cur_neg)
         && $past(eff_phase) == sbs_pkg::SBS_PH_CHARGE)
        |-> gif.gate == `SBS_PAT_CHG_FWD)
        else $error("forward charge pattern wrong");

    chk_rev_pattern: assert property ( // RULE2
        (gif.gate != '0 && $past(gif.gate) != '0 && $past(cur_neg)
         && $past(eff_phase) == sbs_pkg::SBS_PH_FAST)
        |-> gif.gate == `SBS_PAT_CHG_FWD)
        else $error("reverse fast pattern wrong");

    chk_fwd_fast: assert property ( // RULE1
        (gif.gate != '0 && $past(gif.gate) != '0 && !$past(cur_neg)
         && $past(eff_phase) == sbs_pkg::SBS_PH_FAST)
        |-> gif.gate == `SBS_PAT_FST_FWD)
        else $error("forward fast pattern wrong");

    chk_rev_charge: assert property ( // RULE2
        (gif.gate != '0 && $past(gif.gate) != '0 && $past(cur_neg)
         && $past(eff_phase) == sbs_pkg::SBS_PH_CHARGE)
        |-> gif.gate == `SBS_PAT_FST_FWD)
        else $error("reverse charge pattern wrong");

    chk_stat_set_wins: assert property (
        (events != '0 && reg_wr_i && reg_addr_i == `SBS_ADDR_STAT)
        |=> (status_reg & $past(events)) == $past(events))
        else $error("event lost against status clear");
endmodule : sbs_bridge_ctrl
`default_nettype wire

// >>> tb/sbs_host_model.sv
// Host step controller model that drives the control pins
`timescale 1ns/10ps
`default_nettype none
module sbs_host_model (
    // Clock
    input  wire logic ref_clk_i,
    // Control pins
    output var logic  step_clk_o,
    output var logic  drive_reset_n_o,
    output var logic  enable_o,
    output var logic  dir_o
);
    // all pins low at power up
    initial
    begin
        step_clk_o      = 1'h0;
        drive_reset_n_o = 1'h0;
        enable_o        = 1'h0;
        dir_o           = 1'h0;
    end

    // reset and enable raised last, dropped first
    task automatic pins(input logic rst_n, input logic en);
        @(posedge ref_clk_i);
        drive_reset_n_o <= rst_n;
        enable_o        <= en;
    endtask : pins

    // Direction settles one cycle before the step edge
    task automatic step(input logic dir, input int n);
        repeat (n)
        begin
            @(posedge ref_clk_i);
            dir_o <= dir;
            @(posedge ref_clk_i);
            step_clk_o <= 1'h1;
            repeat (2) @(posedge ref_clk_i);
            step_clk_o <= 1'h0;
            repeat (2) @(posedge ref_clk_i);
        end
    endtask : step
endmodule : sbs_host_model
`default_nettype wire

// >>> tb/sbs_bridge_ctrl_tb.sv
// Self-checking bench for the bridge switch control block
`timescale 1ns/10ps
`default_nettype none
module sbs_bridge_ctrl_tb;
    // ------------------------------------------------------------
    // Design and partner
    // ------------------------------------------------------------
    logic        ref_clk, reset_n, thermal, wr, rd, irq;
    logic [11:0] osc_mv;
    logic [2:0]  phase_req;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, d;
    logic        hs_a, hs_b, ls_a, ls_b, flag, flag_oe;
    logic        stp, drst_n, en, dir;
    int          fail_count = 0;
    int          compares = 0;
    wire  [3:0]  gates = {hs_a, hs_b, ls_a, ls_b};
    // Open-drain flag pin with pull-up
    wire         flag_pin = flag_oe ? flag : 1'h1;
    logic [2:0]  ph_t [6] = '{3'h2, 3'h4, 3'h1, 3'h4, 3'h1, 3'h2};
    logic [3:0]  pt_t [6] = '{4'h3, 4'h6, 4'h9, 4'h9, 4'h6, 4'h3};

    sbs_host_model sbs_host_model_i (
        .ref_clk_i       (ref_clk),
        .step_clk_o      (stp),
        .drive_reset_n_o (drst_n),
        .enable_o        (en),
        .dir_o           (dir)
    );
    sbs_bridge_ctrl sbs_bridge_ctrl_i (
        .ref_clk_i               (ref_clk),
        .reset_n_i               (reset_n),
        .step_clk_i              (stp),
        .drive_reset_n_i         (drst_n),
        .enable_i                (en),
        .dir_i                   (dir),
        .osc_mv_i                (osc_mv),
        .phase_req_i             (phase_req),
        .thermal_trip_i          (thermal),
        .high_side_switch_a_o    (hs_a),
        .high_side_switch_b_o    (hs_b),
        .low_side_switch_a_o     (ls_a),
        .low_side_switch_b_o     (ls_b),
        .initial_state_flag_o    (flag),
        .initial_state_flag_oe_o (flag_oe),
        .reg_addr_i              (addr),
        .reg_wdata_i             (wdata),
        .reg_wr_i                (wr),
        .reg_rd_i                (rd),
        .reg_rdata_o             (rdata),
        .irq_o                   (irq)
    );
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        wr    <= 1'h1;
        addr  <= a;
        wdata <= v;
        @(posedge ref_clk);
        wr <= 1'h0;
    endtask : reg_write
    // Read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        rd   <= 1'h1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 1'h0;
        #1 v = rdata;
    endtask : reg_read
    task automatic gap(input logic [3:0] pat);
        @(posedge ref_clk);
        repeat (14)
        begin
            @(posedge ref_clk);
            #1 check("dead gap", gates, 32'h0);
        end
        @(posedge ref_clk);
        #1 check("pattern", gates, pat);
    endtask : gap
    task automatic ramp(input logic [11:0] mv);
        @(posedge ref_clk);
        osc_mv <= mv;
        repeat (5) @(posedge ref_clk);
    endtask : ramp
    task automatic tally_and_finish();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        ref_clk = 1'h0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial
    begin
        #200000;
        fail_count++;
        $display("watchdog expired");
        tally_and_finish();
    end
    initial
    begin
        {reset_n, thermal, wr, rd, addr, wdata} = '0;
        osc_mv    = 12'h000;
        phase_req = 3'h1;
        repeat (2) @(posedge ref_clk);
        #1 check("off in reset", gates, 32'h0);
        check("flag in reset", flag_pin, 32'h0);
        @(posedge ref_clk);
        reset_n <= 1'h1;
        reg_read(8'h00, d);
        check("ctrl", d, 32'h1);
        reg_read(8'h08, d);
        check("mask", d, 32'h0);
        reg_read(8'h10, d);
        check("unmapped", d, 32'h0);
        // Enable without reset release
        sbs_host_model_i.pins(1'h0, 1'h1);
        sbs_host_model_i.step(1'h0, 3);
        reg_read(8'h0C, d);
        check("pos held", d & 32'hF, 32'h0);
        check("flag held", flag_pin, 32'h0);
        check("off held", gates, 32'h0);
        reg_read(8'h04, d);
        check("no step", d & 32'h1, 32'h0);
        sbs_host_model_i.pins(1'h1, 1'h1);
        gap(4'h9);
        for (int i = 0; i < 6; i++)
        begin
            if (i == 3)
            begin
                sbs_host_model_i.step(1'h0, 8);
                repeat (20) @(posedge ref_clk);
                #1 check("reverse charge", gates, 32'h6);
                check("flag moved", flag_pin, 32'h1);
                reg_read(8'h0C, d);
                check("pos up", d & 32'hF, 32'h8);
            end
            @(posedge ref_clk);
            phase_req <= ph_t[i];
            gap(pt_t[i]);
        end
        // Enable low in slow decay, then steps backwards
        sbs_host_model_i.pins(1'h1, 1'h0);
        repeat (2) @(posedge ref_clk);
        #1 check("enable off", gates, 32'h0);
        sbs_host_model_i.step(1'h1, 3);
        #1 check("stay off", gates, 32'h0);
        reg_read(8'h0C, d);
        check("pos down", d & 32'hF, 32'h5);
        sbs_host_model_i.pins(1'h1, 1'h1);
        gap(4'h3);
        check("irq masked", irq, 32'h0);
        reg_write(8'h08, 32'h2);
        @(posedge ref_clk);
        thermal <= 1'h1;
        repeat (2) @(posedge ref_clk);
        #1 check("thermal off", gates, 32'h0);
        repeat (3) @(posedge ref_clk);
        #1 check("irq up", irq, 32'h1);
        reg_read(8'h04, d);
        check("trip status", d & 32'h2, 32'h2);
        @(posedge ref_clk);
        thermal <= 1'h0;
        gap(4'h3);
        reg_write(8'h04, 32'h7);
        repeat (3) @(posedge ref_clk);
        #1 check("irq clear", irq, 32'h0);
        // Chop rise after a step, with hysteresis
        sbs_host_model_i.step(1'h0, 1);
        ramp(12'h7CF);
        reg_read(8'h04, d);
        check("below high", d & 32'h4, 32'h0);
        ramp(12'h7D0);
        reg_read(8'h04, d);
        check("chop restart", d & 32'h4, 32'h4);
        repeat (13) @(posedge ref_clk);
        #1 check("sense charge", gates, 32'h9);
        repeat (27) @(posedge ref_clk);
        #1 check("back to slow", gates, 32'h3);
        reg_write(8'h04, 32'h4);
        sbs_host_model_i.step(1'h0, 1);
        ramp(12'h258);
        ramp(12'h7D0);
        reg_read(8'h04, d);
        check("level held", d & 32'h4, 32'h0);
        ramp(12'h1F4);
        ramp(12'h7D0);
        reg_read(8'h04, d);
        check("rise again", d & 32'h4, 32'h4);
        sbs_host_model_i.pins(1'h0, 1'h0);
        repeat (3) @(posedge ref_clk);
        #1 check("power down", gates, 32'h0);
        check("flag down", flag_pin, 32'h0);
        tally_and_finish();
    end
endmodule : sbs_bridge_ctrl_tb
`default_nettype wire
